//--- src/spl_defines.svh
// Register offsets, reset values and loop limits of the servo position loop.
// Included by the PWM generator, the servo loop and the bench; the package does not include it.
`ifndef SPL_DEFINES_SVH
`define SPL_DEFINES_SVH

// Register byte offsets, one aligned 32-bit word each
`define SPL_ADDR_PGAIN 8'h00
`define SPL_ADDR_IGAIN 8'h04
`define SPL_ADDR_DGAIN 8'h08
`define SPL_ADDR_PERIOD 8'h0C
`define SPL_ADDR_CMDPOS 8'h10
`define SPL_ADDR_MEASPOS 8'h14
`define SPL_ADDR_VEL 8'h18
`define SPL_ADDR_ERR 8'h1C
`define SPL_ADDR_STATUS 8'h20
`define SPL_ADDR_COUNTS 8'h24

// Field positions
`define SPL_STATUS_SAT_BIT 16
`define SPL_FRAC_BITS 8

// Reset values
`define SPL_RST_GAIN 16'h0000
`define SPL_RST_PERIOD 8'h08
`define SPL_RST_CMDPOS 32'h00000000
`define SPL_RST_PWM_CNT 10'h3FF

// Compensator limits
`define SPL_DUTY_POS_LIMIT 16'h01F5
`define SPL_DUTY_NEG_LIMIT 16'hFE0B
`define SPL_DUTY_OFFSET 10'h200
`define SPL_DUTY_MID 10'h200
`define SPL_SAT24_MAX 32'h007FFFFF
`define SPL_SAT24_MIN 32'hFF800000
`define SPL_SAT16_MAX 32'h00007FFF
`define SPL_SAT16_MIN 32'hFFFF8000

`endif

//--- src/spl_pkg.sv
// Types shared by the servo position loop design files.
// Assumes spl_defines.svh is on the include path.
package spl_pkg;

	// Register port request
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} spl_bus_req_t;

	// Servo calculation phases
	typedef enum logic [1:0] {
		SPL_IDLE = 2'b00,
		SPL_POS = 2'b01,
		SPL_PID = 2'b10
	} spl_phase_t;

	// Pulse counter state
	typedef struct packed {
		logic [1:0] sync;
		logic last;
		logic [15:0] count;
	} spl_cnt_state_t;

	// PWM generator state
	typedef struct packed {
		logic [9:0] cnt;
		logic [9:0] duty;
		logic out;
	} spl_pwm_state_t;

	// Loop state
	typedef struct packed {
		logic [31:0] rdata;
		logic [15:0] pgain;
		logic [15:0] igain;
		logic [15:0] dgain;
		logic [7:0] period;
		logic [31:0] cmd_pos;
		spl_phase_t phase;
		logic [7:0] tick_cnt;
		logic pwm_last;
		logic tick;
		logic [15:0] up_prev;
		logic [15:0] dn_prev;
		logic [15:0] velocity;
		logic [31:0] meas_pos;
		logic [15:0] err;
		logic [15:0] err_prev;
		logic [15:0] integ;
		logic [9:0] duty;
		logic sat;
	} spl_state_t;

endpackage : spl_pkg

//--- src/spl_pulse_counter.sv
// Free-running 16-bit counter of encoder pulses from an outside pin.
// Assumes pulses are wider than two clock periods and gaps likewise.
`timescale 1ns/1ps
`default_nettype none
module spl_pulse_counter
	import spl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Pulse pin
	input wire logic pulse_in,
	// Count
	output logic [15:0] count
);
	spl_cnt_state_t s_q;
	spl_cnt_state_t s_d;

	// Synchronise, find the rising edge, count it, never clear
	always_comb
	begin
		s_d = s_q;
		s_d.sync = {s_q.sync[0], pulse_in};
		s_d.last = s_q.sync[1];
		if (s_q.sync[1] && !s_q.last)
		begin
			s_d.count = s_q.count + 16'h0001;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign count = s_q.count;
endmodule : spl_pulse_counter
`default_nettype wire

//--- src/spl_pwm_gen.sv
// 10-bit PWM generator; duty 0 gives 0% and 1023 gives almost 100%.
// New duty is taken only at the start of a PWM period to avoid runt pulses.
`timescale 1ns/1ps
`default_nettype none
`include "spl_defines.svh"
module spl_pwm_gen
	import spl_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Duty in
	input wire logic [9:0] duty,
	// PWM out
	output logic pwm
);
	spl_pwm_state_t s_q;
	spl_pwm_state_t s_d;

	// Period counter and compare
	always_comb
	begin
		s_d = s_q;
		s_d.cnt = s_q.cnt + 10'h001;
		if (s_q.cnt == 10'h3FF)
			s_d.duty = duty;
		s_d.out = (s_d.cnt < s_d.duty);
	end

	// State register, reset to mid duty for zero torque
	// Count resets to its last value so the first period is whole
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '{cnt: `SPL_RST_PWM_CNT, duty: `SPL_DUTY_MID, out: 1'b0};
		else if (ce)
			s_q <= s_d;
	end

	assign pwm = s_q.out;
endmodule : spl_pwm_gen
`default_nettype wire

//--- src/spl_servo_loop.sv
// Servo position loop: encoder pulse counting, position tracking, PID
// compensator with anti-windup, and offset 10-bit PWM duty for an H-bridge.
// Assumes encoder pulse pins are asynchronous and registers are reached
// over a plain one-cycle strobe port on clk.
// Assumes the encoder stays under the per-period count limit and that the
// H-bridge reads mid duty as zero torque.
//
// Overview of operation
// - One full servo calculation per servo tick, never otherwise.
// - Tick counter counts PWM edges, wraps to zero at period, raises tick.
// - Up pulses and down pulses each feed their own 16-bit counter.
// - Pulse counters run freely and are never cleared by the loop.
// - Per-period counts are present minus saved values, modulo 2^16.
// - Velocity is up count minus down count, signed, per servo period.
// - Measured position is 32 bits: 24 whole counts, 8 fractional bits.
// - Each update adds measured velocity into measured position.
// - Error is commanded minus measured whole counts, cut to signed 16 bits.
// - Each term is a signed 16x16 product from adjustable 16-bit gains.
// - Proportional term is proportional gain times present error.
// - Integral sum accumulates error each update, times integral gain.
// - Saturated previous output stops error accumulation into the integral.
// - Derivative term is derivative gain times error change since last update.
// - Terms add with 32-bit addition, then saturate to signed 24 bits.
// - Duty command is upper 16 bits of the 24-bit sum.
// - Duty command keeps PWM duty between 1% and 99%.
// - Out-of-limit command clamps to the limit and sets saturated flag.
// - Duty register gets command plus 512; 0 is 0%, 1023 is almost 100%.
//
// Chosen here: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "spl_defines.svh"
module spl_servo_loop
	import spl_pkg::*;
(
	// Clock, reset and clock enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Encoder decoder pulses
	input wire logic up_pulse_in,
	input wire logic down_pulse_in,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Motor drive and status
	output logic motor_drive_pwm,
	output logic servo_tick,
	output logic saturated
);
	spl_state_t s_q;
	spl_state_t s_d;
	spl_bus_req_t req;
	logic [15:0] up_pulse_counter;
	logic [15:0] down_pulse_counter;
	logic pwm;

	// Signed 16x16 product
	function automatic logic [31:0] spl_mul16(input logic [15:0] a, input logic [15:0] b);
		logic signed [31:0] p;
		p = $signed(a) * $signed(b);
		return p;
	endfunction : spl_mul16

	// Clamp a signed 32-bit value into signed 16 bits
	function automatic logic [15:0] spl_sat16(input logic [31:0] v);
		logic [15:0] r;
		r = v[15:0];
		if ($signed(v) > $signed(`SPL_SAT16_MAX))
			r = 16'h7FFF;
		else if ($signed(v) < $signed(`SPL_SAT16_MIN))
			r = 16'h8000;
		return r;
	endfunction : spl_sat16

	// Sign-extend 16 bits to 32
	function automatic logic [31:0] spl_sext16(input logic [15:0] v);
		return {{16{v[15]}}, v};
	endfunction : spl_sext16

	// Clamp a signed 32-bit value into signed 24 bits
	function automatic logic [31:0] spl_sat24(input logic [31:0] v);
		logic [31:0] r;
		r = v;
		if ($signed(v) > $signed(`SPL_SAT24_MAX))
			r = `SPL_SAT24_MAX;
		else if ($signed(v) < $signed(`SPL_SAT24_MIN))
			r = `SPL_SAT24_MIN;
		return r;
	endfunction : spl_sat24

	// Request carrier
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	// Encoder pulse counters
	spl_pulse_counter u_up_cnt (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pulse_in(up_pulse_in),
		.count(up_pulse_counter)
	);

	spl_pulse_counter u_dn_cnt (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.pulse_in(down_pulse_in),
		.count(down_pulse_counter)
	);

	// PWM output stage
	spl_pwm_gen u_pwm (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.duty(s_q.duty),
		.pwm(pwm)
	);

	// Next-state logic: register port, tick counter and servo phases
	always_comb
	begin
		logic [15:0] up_delta;
		logic [15:0] dn_delta;
		logic [15:0] vel;
		logic [31:0] new_pos;
		logic [23:0] err_wide;
		logic [15:0] integ_n;
		logic [15:0] derr;
		logic [31:0] p_term;
		logic [31:0] i_term;
		logic [31:0] d_term;
		logic [31:0] sum;
		logic [31:0] sum24;
		logic [15:0] cmd;
		s_d = s_q;
		up_delta = '0;
		dn_delta = '0;
		vel = '0;
		new_pos = '0;
		err_wide = '0;
		integ_n = '0;
		derr = '0;
		p_term = '0;
		i_term = '0;
		d_term = '0;
		sum = '0;
		sum24 = '0;
		cmd = '0;

		// Register writes
		if (req.wr)
		begin
			if (req.addr == `SPL_ADDR_PGAIN)
				s_d.pgain = req.wdata[15:0];
			else if (req.addr == `SPL_ADDR_IGAIN)
				s_d.igain = req.wdata[15:0];
			else if (req.addr == `SPL_ADDR_DGAIN)
				s_d.dgain = req.wdata[15:0];
			else if (req.addr == `SPL_ADDR_PERIOD)
				s_d.period = req.wdata[7:0];
			else if (req.addr == `SPL_ADDR_CMDPOS)
				s_d.cmd_pos = req.wdata;
		end

		// Register reads, data valid for one cycle only
		s_d.rdata = '0;
		if (req.rd)
		begin
			if (req.addr == `SPL_ADDR_PGAIN)
				s_d.rdata = {16'h0000, s_q.pgain};
			else if (req.addr == `SPL_ADDR_IGAIN)
				s_d.rdata = {16'h0000, s_q.igain};
			else if (req.addr == `SPL_ADDR_DGAIN)
				s_d.rdata = {16'h0000, s_q.dgain};
			else if (req.addr == `SPL_ADDR_PERIOD)
				s_d.rdata = {24'h000000, s_q.period};
			else if (req.addr == `SPL_ADDR_CMDPOS)
				s_d.rdata = s_q.cmd_pos;
			else if (req.addr == `SPL_ADDR_MEASPOS)
				s_d.rdata = s_q.meas_pos;
			else if (req.addr == `SPL_ADDR_VEL)
				s_d.rdata = spl_sext16(s_q.velocity);
			else if (req.addr == `SPL_ADDR_ERR)
				s_d.rdata = spl_sext16(s_q.err);
			else if (req.addr == `SPL_ADDR_STATUS)
				s_d.rdata = {15'h0000, s_q.sat, 6'h00, s_q.duty};
			else if (req.addr == `SPL_ADDR_COUNTS)
				s_d.rdata = {down_pulse_counter, up_pulse_counter};
		end

		// Servo tick counter clocked by PWM rising edges
		// Equality compare: a period written below the count waits for wraparound
		s_d.pwm_last = pwm;
		s_d.tick = 1'b0;
		if (pwm && !s_q.pwm_last)
		begin
			if (s_q.tick_cnt == s_q.period)
			begin
				s_d.tick_cnt = 8'h00;
				s_d.tick = 1'b1;
			end
			else
			begin
				s_d.tick_cnt = s_q.tick_cnt + 8'h01;
			end
		end

		// Servo calculation phases
		// Position and compensator run in separate cycles to keep logic depth down
		case (s_q.phase)
			SPL_IDLE:
			begin
				if (s_q.tick)
					s_d.phase = SPL_POS;
			end
			SPL_POS:
			begin
				// Position update and error
				up_delta = up_pulse_counter - s_q.up_prev;
				dn_delta = down_pulse_counter - s_q.dn_prev;
				vel = up_delta - dn_delta;
				new_pos = s_q.meas_pos + {{8{vel[15]}}, vel, 8'h00};
				err_wide = s_q.cmd_pos[31:`SPL_FRAC_BITS] - new_pos[31:`SPL_FRAC_BITS];
				s_d.velocity = vel;
				s_d.meas_pos = new_pos;
				s_d.err = err_wide[15:0];
				s_d.up_prev = up_pulse_counter;
				s_d.dn_prev = down_pulse_counter;
				s_d.phase = SPL_PID;
			end
			SPL_PID:
			begin
				// Integral with anti-windup
				// Accumulator holds while the last output was clamped
				if (s_q.sat)
					integ_n = s_q.integ;
				else
					integ_n = spl_sat16(spl_sext16(s_q.integ) + spl_sext16(s_q.err));
				derr = spl_sat16(spl_sext16(s_q.err) - spl_sext16(s_q.err_prev));
				p_term = spl_mul16(s_q.pgain, s_q.err);
				i_term = spl_mul16(s_q.igain, integ_n);
				d_term = spl_mul16(s_q.dgain, derr);
				sum = p_term + i_term + d_term;
				// Saturate to 24 bits
				sum24 = spl_sat24(sum);
				cmd = sum24[23:8];
				// Duty limits keep the tick counter clocked
				if ($signed(cmd) > $signed(`SPL_DUTY_POS_LIMIT))
				begin
					cmd = `SPL_DUTY_POS_LIMIT;
					s_d.sat = 1'b1;
				end
				else if ($signed(cmd) < $signed(`SPL_DUTY_NEG_LIMIT))
				begin
					cmd = `SPL_DUTY_NEG_LIMIT;
					s_d.sat = 1'b1;
				end
				else
				begin
					s_d.sat = 1'b0;
				end
				s_d.duty = cmd[9:0] + `SPL_DUTY_OFFSET;
				s_d.integ = integ_n;
				s_d.err_prev = s_q.err;
				s_d.phase = SPL_IDLE;
			end
			default:
			begin
				s_d.phase = SPL_IDLE;
			end
		endcase
	end

	// State register, frozen while ce is low
	// Reset duty is mid scale, so the motor starts with no torque
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_q <= '0;
			s_q.pgain <= `SPL_RST_GAIN;
			s_q.igain <= `SPL_RST_GAIN;
			s_q.dgain <= `SPL_RST_GAIN;
			s_q.period <= `SPL_RST_PERIOD;
			s_q.cmd_pos <= `SPL_RST_CMDPOS;
			s_q.phase <= SPL_IDLE;
			s_q.duty <= `SPL_DUTY_MID;
		end
		else if (ce)
		begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign reg_rdata = s_q.rdata;
	assign motor_drive_pwm = pwm;
	assign servo_tick = s_q.tick;
	assign saturated = s_q.sat;
endmodule : spl_servo_loop
`default_nettype wire

//--- dv/spl_servo_loop_properties.sv
// Port checks of the servo loop: PWM timing, servo tick, saturation, reads.
// Bound from tb; assumes ce is held high.
`timescale 1ns/1ps
`default_nettype none
module spl_servo_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Watched ports
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic motor_drive_pwm,
	input wire logic servo_tick,
	input wire logic saturated
);
	typedef struct packed {
		logic last;
		logic seen;
		logic sat;
		logic tseen;
		logic [10:0] cyc;
		logic [10:0] hi;
		logic [15:0] tcyc;
	} spl_chk_t;
	spl_chk_t s_q;
	logic rise;
	logic fall;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// PWM edges seen on the sampled level
	assign rise = motor_drive_pwm && !s_q.last;
	assign fall = !motor_drive_pwm && s_q.last;
	// Period, high time and tick spacing counters
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= '0;
		else
		begin
			s_q.last <= motor_drive_pwm;
			s_q.seen <= s_q.seen | rise;
			s_q.sat <= rise ? saturated : s_q.sat;
			s_q.tseen <= s_q.tseen | servo_tick;
			s_q.cyc <= rise ? 11'h000 : s_q.cyc + 11'h001;
			s_q.hi <= rise ? 11'h001 : s_q.hi + {10'h000, motor_drive_pwm};
			s_q.tcyc <= servo_tick ? 16'h0000 : s_q.tcyc + 16'h0001;
		end
	end
	chk_tick_single: assert property (servo_tick |=> !servo_tick)
		else $error("servo tick longer than one cycle");
	chk_tick_in_pwm: assert property (servo_tick |-> motor_drive_pwm)
		else $error("servo tick outside PWM high time");
	chk_tick_spacing: assert property (servo_tick && s_q.tseen |-> s_q.tcyc[9:0] == 10'h3FF)
		else $error("servo ticks not whole PWM periods apart");
	chk_sat_on_update: assert property ($changed(saturated) |-> $past(servo_tick, 3))
		else $error("saturated flag moved outside an update");
	chk_pwm_period: assert property (rise && s_q.seen |-> s_q.cyc == 11'h3FF)
		else $error("PWM period not 1024 cycles");
	chk_duty_limits: assert property (fall |-> s_q.hi inside {[11'h00B:11'h3F5]})
		else $error("PWM high time out of limits");
	chk_sat_clamped: assert property (fall && s_q.sat |-> s_q.hi == 11'h00B || s_q.hi == 11'h3F5)
		else $error("saturated duty not at a limit");
	chk_read_quiet: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
		else $error("read data outside read cycle");
	cov_sat: cover property ($rose(saturated));
	cov_unsat: cover property ($fell(saturated));
	cov_read: cover property (reg_rdata != 32'h0000_0000);
endmodule : spl_servo_chk
`default_nettype wire

//--- dv/spl_enc_model.sv
// Encoder decoder model: up and down pulse trains on request.
// Assumes the loop synchronises the pins to clk.
`timescale 1ns/1ps
`default_nettype none
module spl_enc_model (
	// Clock
	input wire logic clk,
	// Pulse pins, idle low
	output logic up_pulse,
	output logic down_pulse
);
	initial up_pulse = 1'b0;
	initial down_pulse = 1'b0;
	// Whole pulses, few per period, far under the count limit
	task automatic send(input int n_up, input int n_dn);
		repeat (n_up) pulse(1'b1);
		repeat (n_dn) pulse(1'b0);
	endtask : send
	// Three cycles high, three low
	task automatic pulse(input logic up);
		@(posedge clk);
		up_pulse <= up;
		down_pulse <= !up;
		repeat (3) @(posedge clk);
		up_pulse <= 1'b0;
		down_pulse <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : pulse
endmodule : spl_enc_model
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench of the servo position loop.
// Assumes the encoder model on the pulse pins; ce held high.
`timescale 1ns/1ps
`default_nettype none
`include "spl_defines.svh"
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic pwm, tick, sat, up_p, dn_p;
	int fail_count = 0;
	int n_tests = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	// Design and encoder model
	spl_servo_loop uut (.clk, .rst_n, .ce(1'b1), .up_pulse_in(up_p), .down_pulse_in(dn_p),
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .motor_drive_pwm(pwm),
		.servo_tick(tick), .saturated(sat));
	spl_enc_model enc (.clk, .up_pulse(up_p), .down_pulse(dn_p));
	// Hang limit
	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 40000)
		begin
			fail_count++;
			results();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		check(what, exp, reg_rdata);
	endtask : rd
	task automatic st(input logic [31:0] exp);
		rd(`SPL_ADDR_STATUS, exp, "status");
	endtask : st
	// Reset; fast sets tick period 0 at the release edge
	task automatic restart(input logic fast);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		reg_addr <= `SPL_ADDR_PERIOD;
		reg_wdata <= 32'h0000_0000;
		reg_wr <= fast;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : restart
	// Next servo tick, then let the update land
	task automatic wait_tick();
		int n;
		n = 0;
		@(negedge clk);
		while (tick !== 1'b1 && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
		check("servo tick", 32'h0000_0001, {31'h0, tick});
		repeat (3) @(negedge clk);
	endtask : wait_tick
	task automatic t_reset();
		rd(`SPL_ADDR_IGAIN, 32'h0, "integral gain");
		rd(`SPL_ADDR_PERIOD, 32'h0000_0008, "tick period");
		st(32'h0000_0200);
		wr(`SPL_ADDR_PGAIN, 32'hFFFF_8001);
		rd(`SPL_ADDR_PGAIN, 32'h0000_8001, "proportional gain");
		wr(`SPL_ADDR_MEASPOS, 32'h1234_5678);
		rd(`SPL_ADDR_MEASPOS, 32'h0, "position");
		rd(8'h28, 32'h0, "unmapped");
		$display("test reset done");
	endtask : t_reset
	task automatic t_position();
		restart(1'b1);
		wait_tick();
		enc.send(5, 2);
		wait_tick();
		rd(`SPL_ADDR_VEL, 32'h0000_0003, "velocity");
		rd(`SPL_ADDR_MEASPOS, 32'h0000_0300, "position");
		enc.send(1, 4);
		wait_tick();
		rd(`SPL_ADDR_VEL, 32'hFFFF_FFFD, "velocity");
		rd(`SPL_ADDR_MEASPOS, 32'h0, "position");
		rd(`SPL_ADDR_COUNTS, 32'h0006_0006, "counts");
		wait_tick();
		rd(`SPL_ADDR_VEL, 32'h0, "velocity");
		$display("test position done");
	endtask : t_position
	task automatic t_pid();
		logic [31:0] cmd [5] = '{32'h0100_1000, 32'hFFFF_FD00, 32'hFFFF_F000, 32'h007F_FF00,
			32'h0};
		logic [31:0] err [5] = '{32'h0000_0010, 32'hFFFF_FFFD, 32'hFFFF_FFF0, 32'h0000_7FFF,
			32'h0};
		logic [31:0] sts [5] = '{32'h0001_03F5, 32'h0000_0080, 32'h0001_000B, 32'h0001_03F5,
			32'h0000_0200};
		restart(1'b1);
		wr(`SPL_ADDR_PGAIN, 32'h0000_7FFF);
		for (int i = 0; i < 5; i++)
		begin
			wr(`SPL_ADDR_CMDPOS, cmd[i]);
			wait_tick();
			rd(`SPL_ADDR_ERR, err[i], "error");
			st(sts[i]);
			check("saturated", {31'h0, sts[i][16]}, {31'h0, sat});
		end
		$display("test pid done");
	endtask : t_pid
	task automatic t_windup();
		restart(1'b1);
		wait_tick();
		wr(`SPL_ADDR_CMDPOS, 32'h0000_1000);
		wr(`SPL_ADDR_IGAIN, 32'h0000_0100);
		wr(`SPL_ADDR_PGAIN, 32'h0000_7FFF);
		repeat (3) wait_tick();
		st(32'h0001_03F5);
		wr(`SPL_ADDR_PGAIN, 32'h0);
		wait_tick();
		st(32'h0000_0210);
		wait_tick();
		st(32'h0000_0220);
		$display("test windup done");
	endtask : t_windup
	task automatic t_deriv();
		logic [31:0] n;
		restart(1'b1);
		wait_tick();
		wr(`SPL_ADDR_CMDPOS, 32'h0000_1000);
		wr(`SPL_ADDR_DGAIN, 32'h0000_0100);
		wait_tick();
		st(32'h0000_0210);
		n = 0;
		@(posedge pwm);
		repeat (1024)
		begin
			@(negedge clk);
			n = n + {31'h0, pwm};
		end
		check("PWM high time", 32'h0000_0210, n);
		wait_tick();
		st(32'h0000_0200);
		$display("test derivative done");
	endtask : t_deriv
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results
	initial
	begin
		restart(1'b0);
		t_reset();
		t_position();
		t_pid();
		t_windup();
		t_deriv();
		results();
	end
endmodule : tb
bind spl_servo_loop spl_servo_chk chk (.clk, .rst_n, .reg_rd, .reg_rdata, .motor_drive_pwm,
	.servo_tick, .saturated);
`default_nettype wire
